/* src/bst_pkg.sv */
// ---------------------------------------------------------------
// Shared constants and types of the boundary-scan test port
// ---------------------------------------------------------------
package bst_pkg;

	// Scan path lengths
	localparam int IR_LEN = 4;
	localparam int MODE_LEN = 2;
	localparam int ID_LEN = 32;
	localparam int BSR_LEN = 392;
	localparam int MRR_LEN = 26;
	localparam int BSR_IN = 200;
	localparam int BSR_OUT = BSR_LEN - BSR_IN;
	localparam int FAIL_W = 24;

	// Instruction codes
	localparam logic [3:0] IR_EXTEST = 4'h0;
	localparam logic [3:0] IR_SAMPLE = 4'h1;
	localparam logic [3:0] IR_INTSCAN = 4'h4;
	localparam logic [3:0] IR_CLAMP = 4'h5;
	localparam logic [3:0] IR_HIGHZ = 4'h6;
	localparam logic [3:0] IR_IDCODE = 4'h7;
	localparam logic [3:0] IR_RUNBIST = 4'h8;
	localparam logic [3:0] IR_MODESEL = 4'ha;
	localparam logic [3:0] IR_BYPASS = 4'hf;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// Identification fields, values arbitrary
	localparam logic [3:0] ID_REVISION = 4'h2;
	localparam logic [15:0] ID_PART = 16'h0a5c;
	localparam logic [10:0] ID_VENDOR = 11'h2a6;
	localparam logic ID_PRESENT = 1'b1;
	localparam logic [31:0] ID_VALUE =
		{ID_REVISION, ID_PART, ID_VENDOR, ID_PRESENT};

	// Result register layout
	localparam int MRR_PASS_BIT = 1;
	localparam int MRR_CNT_LSB = 2;
	localparam logic [23:0] FORCED_FAILS = 24'h8e_0000;
	localparam logic [23:0] FAIL_MAX = 24'hff_ffff;

	// Self-test modes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_FORCE_FAIL = 2'h3;

	// Read and write operations of one self-test run
	localparam int SELFTEST_OPS = 14811136;

	// Test access controller states
	typedef enum logic [15:0] {
		TLR = 16'h0001,
		RTI = 16'h0002,
		SEL_DR = 16'h0004,
		CAP_DR = 16'h0008,
		SH_DR = 16'h0010,
		EX1_DR = 16'h0020,
		PA_DR = 16'h0040,
		EX2_DR = 16'h0080,
		UPD_DR = 16'h0100,
		SEL_IR = 16'h0200,
		CAP_IR = 16'h0400,
		SH_IR = 16'h0800,
		EX1_IR = 16'h1000,
		PA_IR = 16'h2000,
		EX2_IR = 16'h4000,
		UPD_IR = 16'h8000
	} bst_tap_state_t;

	// Data path selected by the instruction
	typedef enum logic [4:0] {
		DR_BYPASS = 5'h01,
		DR_ID = 5'h02,
		DR_MODE = 5'h04,
		DR_MRR = 5'h08,
		DR_BSR = 5'h10
	} bst_dr_t;

	// Self-test engine states
	typedef enum logic [1:0] {
		BIST_IDLE = 2'h1,
		BIST_RUN = 2'h2
	} bst_bist_state_t;

endpackage

/* src/bst_bscan_chain.sv */
`timescale 1ns/1ps
module bst_bscan_chain (
	// Link clock and reset
	input wire logic tck,
	input wire logic rst_n,
	// Controls from the test access controller
	input wire logic capture,
	input wire logic shift,
	input wire logic update,
	input wire logic tdi,
	// Cell levels and results
	input wire logic [bst_pkg::BSR_LEN-1:0] cell_in,
	output logic shift_out,
	output logic [bst_pkg::BSR_LEN-1:0] hold,
	output logic upd_tgl
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [bst_pkg::BSR_LEN-1:0] sync1;
		logic [bst_pkg::BSR_LEN-1:0] sync2;
		logic [bst_pkg::BSR_LEN-1:0] sh;
		logic [bst_pkg::BSR_LEN-1:0] hold;
		logic upd_tgl;
	} bst_chain_regs_t;

	bst_chain_regs_t r;
	bst_chain_regs_t next_r;

	// Sample, shift and update of the cells
	always_comb begin
		next_r = r;
		next_r.sync1 = cell_in;
		next_r.sync2 = r.sync1;
		if (capture) begin
			next_r.sh = r.sync2;
		end else if (shift) begin
			next_r.sh = {tdi, r.sh[bst_pkg::BSR_LEN-1:1]};
		end
		if (update) begin
			next_r.hold = r.sh;
			next_r.upd_tgl = ~r.upd_tgl;
		end
	end

	// Register the state
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign shift_out = r.sh[0];
	assign hold = r.hold;
	assign upd_tgl = r.upd_tgl;

endmodule

/* src/bst_selftest_engine.sv */
`timescale 1ns/1ps
module bst_selftest_engine #(
	parameter int OPS = bst_pkg::SELFTEST_OPS
) (
	// Self-test clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests from the link domain
	input wire logic start_tgl,
	input wire logic [1:0] mode,
	// Compare result from the array
	input wire logic read_fail,
	// Outcome
	output logic done_tgl,
	output logic [bst_pkg::MRR_LEN-1:0] result,
	output logic busy
);

	localparam logic [23:0] LAST = 24'(OPS - 1);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		bst_pkg::bst_bist_state_t state;
		logic [2:0] start_sync;
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic [23:0] cnt;
		logic [23:0] fails;
		logic done_tgl;
		logic [bst_pkg::MRR_LEN-1:0] result;
		logic busy;
	} bst_bist_regs_t;

	bst_bist_regs_t r;
	bst_bist_regs_t next_r;

	// Run sequencer and result formatting
	always_comb begin
		logic [23:0] f;
		f = r.fails;
		if (read_fail && r.fails != bst_pkg::FAIL_MAX) begin
			f = r.fails + 24'h1;
		end
		next_r = r;
		next_r.start_sync = {r.start_sync[1:0], start_tgl};
		next_r.mode_s1 = mode;
		next_r.mode_s2 = r.mode_s1;
		case (r.state)
			bst_pkg::BIST_IDLE: begin
				if (r.start_sync[2] ^ r.start_sync[1]) begin
					next_r.cnt = '0;
					next_r.fails = '0;
					next_r.busy = 1'b1;
					next_r.state = bst_pkg::BIST_RUN;
				end
			end
			bst_pkg::BIST_RUN: begin
				next_r.cnt = r.cnt + 24'h1;
				next_r.fails = f;
				if (r.cnt == LAST) begin
					if (r.mode_s2 == bst_pkg::MODE_FORCE_FAIL) begin
						next_r.result = {bst_pkg::FORCED_FAILS, 2'h0};
					end else begin
						next_r.result = {f, f == 24'h0, 1'b0};
					end
					next_r.done_tgl = ~r.done_tgl;
					next_r.busy = 1'b0;
					next_r.state = bst_pkg::BIST_IDLE;
				end
			end
			default: begin
				next_r.state = bst_pkg::BIST_IDLE;
				next_r.busy = 1'b0;
			end
		endcase
	end

	// Register the state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{state: bst_pkg::BIST_IDLE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign done_tgl = r.done_tgl;
	assign result = r.result;
	assign busy = r.busy;

endmodule

/* src/bst_tap.sv */
`timescale 1ns/1ps
module bst_tap #(
	parameter int SELFTEST_OPS = bst_pkg::SELFTEST_OPS
) (
	// Self-test clock and master reset
	input wire logic core_clk,
	input wire logic resetn,
	// Test access port
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdo_oe_n,
	// Device pins observed and driven
	input wire logic [bst_pkg::BSR_IN-1:0] pin_in,
	input wire logic [bst_pkg::BSR_OUT-1:0] core_out,
	input wire logic [bst_pkg::BSR_OUT-1:0] core_oe_n,
	output logic [bst_pkg::BSR_OUT-1:0] dev_out,
	output logic [bst_pkg::BSR_OUT-1:0] dev_oe_n,
	// Self-test array compare and status
	input wire logic read_fail,
	output logic bist_busy
);

	// ---------------------------------------------------------------
	// Decode functions
	// ---------------------------------------------------------------

	// Data path selected by an instruction
	function automatic bst_pkg::bst_dr_t dr_path(input logic [3:0] code);
		case (code)
			bst_pkg::IR_EXTEST: dr_path = bst_pkg::DR_BSR;
			bst_pkg::IR_SAMPLE: dr_path = bst_pkg::DR_BSR;
			bst_pkg::IR_IDCODE: dr_path = bst_pkg::DR_ID;
			bst_pkg::IR_MODESEL: dr_path = bst_pkg::DR_MODE;
			bst_pkg::IR_INTSCAN: dr_path = bst_pkg::DR_MRR;
			default: dr_path = bst_pkg::DR_BYPASS;
		endcase
	endfunction

	// Instructions that put the cell contents on the outputs
	function automatic logic drives_cells(input logic [3:0] code);
		drives_cells = (code == bst_pkg::IR_EXTEST) ||
			(code == bst_pkg::IR_CLAMP);
	endfunction

	// ---------------------------------------------------------------
	// Reset synchronisers
	// ---------------------------------------------------------------
	logic tap_arst_n;
	logic [1:0] tck_rst_sync;
	logic tck_rst_n;
	logic [1:0] core_rst_sync;
	logic core_rst_n;

	// Power-up or TRST resets the test logic
	assign tap_arst_n = trst_n & resetn;

	// Link-side release
	always_ff @(posedge tck or negedge tap_arst_n) begin
		if (!tap_arst_n) begin
			tck_rst_sync <= 2'h0;
		end else begin
			tck_rst_sync <= {tck_rst_sync[0], 1'b1};
		end
	end
	assign tck_rst_n = tck_rst_sync[1];

	// Core-side release
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			core_rst_sync <= 2'h0;
		end else begin
			core_rst_sync <= {core_rst_sync[0], 1'b1};
		end
	end
	assign core_rst_n = core_rst_sync[1];

	// ---------------------------------------------------------------
	// Link-domain state
	// ---------------------------------------------------------------
	typedef struct packed {
		bst_pkg::bst_tap_state_t state;
		logic [bst_pkg::IR_LEN-1:0] ir_sh;
		logic [bst_pkg::IR_LEN-1:0] ir;
		logic bypass;
		logic [bst_pkg::ID_LEN-1:0] id_sh;
		logic [bst_pkg::MODE_LEN-1:0] mode_sh;
		logic [bst_pkg::MRR_LEN-1:0] mrr_sh;
		logic [bst_pkg::MRR_LEN-1:0] result;
		logic start_tgl;
		logic [2:0] done_sync;
		logic drive_cells;
		logic highz;
	} bst_tap_regs_t;

	bst_tap_regs_t r;
	bst_tap_regs_t next_r;
	logic [bst_pkg::MODE_LEN-1:0] mode_reg;
	bst_pkg::bst_dr_t path;
	logic bsr_capture;
	logic bsr_shift;
	logic bsr_update;
	logic bsr_so;
	logic [bst_pkg::BSR_LEN-1:0] bsr_hold;
	logic bsr_upd_tgl;
	logic eng_done_tgl;
	logic [bst_pkg::MRR_LEN-1:0] eng_result;
	logic tdo_bit;

	assign path = dr_path(r.ir);

	// Next state of the access controller
	always_comb begin
		next_r = r;
		case (r.state)
			bst_pkg::TLR: next_r.state = tms ? bst_pkg::TLR : bst_pkg::RTI;
			bst_pkg::RTI: next_r.state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_DR: begin
				next_r.state = tms ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
			end
			bst_pkg::CAP_DR: begin
				next_r.state = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			end
			bst_pkg::SH_DR: begin
				next_r.state = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			end
			bst_pkg::EX1_DR: begin
				next_r.state = tms ? bst_pkg::UPD_DR : bst_pkg::PA_DR;
			end
			bst_pkg::PA_DR: begin
				next_r.state = tms ? bst_pkg::EX2_DR : bst_pkg::PA_DR;
			end
			bst_pkg::EX2_DR: begin
				next_r.state = tms ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
			end
			bst_pkg::UPD_DR: begin
				next_r.state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
			end
			bst_pkg::SEL_IR: begin
				next_r.state = tms ? bst_pkg::TLR : bst_pkg::CAP_IR;
			end
			bst_pkg::CAP_IR: begin
				next_r.state = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
			end
			bst_pkg::SH_IR: begin
				next_r.state = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
			end
			bst_pkg::EX1_IR: begin
				next_r.state = tms ? bst_pkg::UPD_IR : bst_pkg::PA_IR;
			end
			bst_pkg::PA_IR: begin
				next_r.state = tms ? bst_pkg::EX2_IR : bst_pkg::PA_IR;
			end
			bst_pkg::EX2_IR: begin
				next_r.state = tms ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
			end
			bst_pkg::UPD_IR: begin
				next_r.state = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
			end
			default: next_r.state = bst_pkg::TLR;
		endcase

		// Completion of a run crosses back from the self-test clock
		next_r.done_sync = {r.done_sync[1:0], eng_done_tgl};
		if (r.done_sync[2] ^ r.done_sync[1]) begin
			next_r.result = eng_result;
		end

		// Register actions in the current state
		case (r.state)
			bst_pkg::TLR: begin
				next_r.ir = bst_pkg::IR_IDCODE;
			end
			bst_pkg::CAP_IR: begin
				next_r.ir_sh = bst_pkg::IR_CAPTURE;
			end
			bst_pkg::SH_IR: begin
				next_r.ir_sh = {tdi, r.ir_sh[bst_pkg::IR_LEN-1:1]};
			end
			bst_pkg::UPD_IR: begin
				next_r.ir = r.ir_sh;
				if (r.ir_sh == bst_pkg::IR_RUNBIST) begin
					next_r.start_tgl = ~r.start_tgl;
				end
			end
			bst_pkg::CAP_DR: begin
				case (path)
					bst_pkg::DR_ID: next_r.id_sh = bst_pkg::ID_VALUE;
					bst_pkg::DR_MODE: next_r.mode_sh = mode_reg;
					bst_pkg::DR_MRR: next_r.mrr_sh = r.result;
					default: next_r.bypass = 1'b0;
				endcase
			end
			bst_pkg::SH_DR: begin
				case (path)
					bst_pkg::DR_ID: begin
						next_r.id_sh = {tdi, r.id_sh[bst_pkg::ID_LEN-1:1]};
					end
					bst_pkg::DR_MODE: begin
						next_r.mode_sh = {tdi, r.mode_sh[1]};
					end
					bst_pkg::DR_MRR: begin
						next_r.mrr_sh = {tdi, r.mrr_sh[bst_pkg::MRR_LEN-1:1]};
					end
					default: next_r.bypass = tdi;
				endcase
			end
			default: begin
			end
		endcase

		// Output control levels follow the active instruction
		next_r.drive_cells = drives_cells(next_r.ir);
		next_r.highz = (next_r.ir == bst_pkg::IR_HIGHZ);
	end

	// Register the link-domain state
	always_ff @(posedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			r <= '{state: bst_pkg::TLR, ir: bst_pkg::IR_IDCODE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// Mode register, untouched by any reset
	always_ff @(posedge tck) begin
		if (r.state == bst_pkg::UPD_DR && path == bst_pkg::DR_MODE) begin
			mode_reg <= r.mode_sh;
		end
	end

	// ---------------------------------------------------------------
	// Serial output
	// ---------------------------------------------------------------

	// Bit presented by the selected path
	always_comb begin
		case (path)
			bst_pkg::DR_ID: tdo_bit = r.id_sh[0];
			bst_pkg::DR_MODE: tdo_bit = r.mode_sh[0];
			bst_pkg::DR_MRR: tdo_bit = r.mrr_sh[0];
			bst_pkg::DR_BSR: tdo_bit = bsr_so;
			default: tdo_bit = r.bypass;
		endcase
		if (r.state == bst_pkg::SH_IR) begin
			tdo_bit = r.ir_sh[0];
		end
		if (r.state != bst_pkg::SH_IR && r.state != bst_pkg::SH_DR) begin
			tdo_bit = 1'b0; // Idle low outside shifts
		end
	end

	// Launch on the falling edge, driven only while shifting
	always_ff @(negedge tck or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else begin
			tdo <= tdo_bit;
			tdo_oe_n <= !(r.state == bst_pkg::SH_IR ||
				r.state == bst_pkg::SH_DR);
		end
	end

	// ---------------------------------------------------------------
	// Boundary cell chain
	// ---------------------------------------------------------------
	assign bsr_capture = (r.state == bst_pkg::CAP_DR) &&
		(path == bst_pkg::DR_BSR);
	assign bsr_shift = (r.state == bst_pkg::SH_DR) &&
		(path == bst_pkg::DR_BSR);
	assign bsr_update = (r.state == bst_pkg::UPD_DR) &&
		(path == bst_pkg::DR_BSR);

	// Outputs above the inputs in the chain
	bst_bscan_chain u_chain (
		.tck(tck),
		.rst_n(tck_rst_n),
		.capture(bsr_capture),
		.shift(bsr_shift),
		.update(bsr_update),
		.tdi(tdi),
		.cell_in({core_out, pin_in}),
		.shift_out(bsr_so),
		.hold(bsr_hold),
		.upd_tgl(bsr_upd_tgl)
	);

	// ---------------------------------------------------------------
	// Self-test engine
	// ---------------------------------------------------------------
	bst_selftest_engine #(
		.OPS(SELFTEST_OPS)
	) u_engine (
		.clk(core_clk),
		.rst_n(core_rst_n),
		.start_tgl(r.start_tgl),
		.mode(mode_reg),
		.read_fail(read_fail),
		.done_tgl(eng_done_tgl),
		.result(eng_result),
		.busy(bist_busy)
	);

	// ---------------------------------------------------------------
	// Core-domain pin drivers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] drive_sync;
		logic [1:0] highz_sync;
		logic [2:0] upd_sync;
		logic [bst_pkg::BSR_OUT-1:0] hold;
		logic [bst_pkg::BSR_OUT-1:0] dev_out;
		logic [bst_pkg::BSR_OUT-1:0] dev_oe_n;
	} bst_core_regs_t;

	bst_core_regs_t c;
	bst_core_regs_t next_c;

	// Select functional or cell values for each output
	always_comb begin
		next_c = c;
		next_c.drive_sync = {c.drive_sync[0], r.drive_cells};
		next_c.highz_sync = {c.highz_sync[0], r.highz};
		next_c.upd_sync = {c.upd_sync[1:0], bsr_upd_tgl};
		if (c.upd_sync[2] ^ c.upd_sync[1]) begin
			next_c.hold = bsr_hold[bst_pkg::BSR_LEN-1:bst_pkg::BSR_IN];
		end
		if (c.highz_sync[1]) begin
			next_c.dev_out = core_out;
			next_c.dev_oe_n = '1;
		end else if (c.drive_sync[1]) begin
			next_c.dev_out = c.hold;
			next_c.dev_oe_n = '0;
		end else begin
			next_c.dev_out = core_out;
			next_c.dev_oe_n = core_oe_n;
		end
	end

	// Register the core-domain state
	always_ff @(posedge core_clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			c <= '{dev_oe_n: '1, default: '0};
		end else begin
			c <= next_c;
		end
	end

	assign dev_out = c.dev_out;
	assign dev_oe_n = c.dev_oe_n;

endmodule

/* test/bst_checker.sv */
`timescale 1ns/1ps
// ----
// Port checker
// ----
module bst_checker #(
	parameter int SELFTEST_OPS = 20
) (
	// Clocks and resets
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic tck,
	input wire logic trst_n,
	// Link
	input wire logic tms,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	// Pins and status
	input wire logic [bst_pkg::BSR_OUT-1:0] core_out,
	input wire logic [bst_pkg::BSR_OUT-1:0] core_oe_n,
	input wire logic [bst_pkg::BSR_OUT-1:0] dev_out,
	input wire logic [bst_pkg::BSR_OUT-1:0] dev_oe_n,
	input wire logic bist_busy
);
	logic [31:0] busy_cnt;

	// Counts cycles of one self-test run
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy_cnt <= 32'h0000_0000;
		end else if (bist_busy) begin
			busy_cnt <= busy_cnt + 32'h0000_0001;
		end else begin
			busy_cnt <= 32'h0000_0000;
		end
	end

	sequence s_tms_five;
		tms [*5];
	endsequence
	property p_tlr;
		@(posedge tck) disable iff (!trst_n || !resetn)
		s_tms_five |-> ##1 tdo_oe_n;
	endproperty
	a_tlr: assert property (p_tlr)
		else $error("tdo enabled after five tms high");
	property p_oe_rise;
		@(posedge tck) disable iff (!trst_n || !resetn)
		!$past(tdo_oe_n) && tdo_oe_n |-> $past(tms);
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("shift left without tms high");
	property p_oe_fall;
		@(posedge tck) disable iff (!trst_n || !resetn)
		$fell(tdo_oe_n) |-> !$past(tms);
	endproperty
	a_oe_fall: assert property (p_oe_fall)
		else $error("shift entered without tms low");
	property p_tdo_idle;
		@(posedge tck) disable iff (!trst_n || !resetn)
		tdo_oe_n |-> !tdo;
	endproperty
	a_tdo_idle: assert property (p_tdo_idle)
		else $error("tdo not idle outside shift");
	property p_busy_len;
		@(posedge core_clk) disable iff (!resetn)
		$fell(bist_busy) |-> busy_cnt == 32'(SELFTEST_OPS);
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("self-test run length wrong");
	property p_busy_max;
		@(posedge core_clk) disable iff (!resetn)
		bist_busy |-> busy_cnt < 32'(SELFTEST_OPS);
	endproperty
	a_busy_max: assert property (p_busy_max)
		else $error("self-test run too long");
	property p_dev_oe;
		@(posedge core_clk) disable iff (!resetn)
		dev_oe_n == '1 || dev_oe_n == '0 ||
			dev_oe_n == $past(core_oe_n);
	endproperty
	a_dev_oe: assert property (p_dev_oe)
		else $error("pad enables neither core nor forced");
	property p_dev_out;
		@(posedge core_clk) disable iff (!resetn)
		(dev_oe_n != '1 && dev_oe_n != '0) |->
			dev_out == $past(core_out);
	endproperty
	a_dev_out: assert property (p_dev_out)
		else $error("pad outputs do not follow core");
endmodule

bind bst_tap bst_checker #(.SELFTEST_OPS(SELFTEST_OPS)) i_chk (
	.core_clk(core_clk),
	.resetn(resetn),
	.tck(tck),
	.trst_n(trst_n),
	.tms(tms),
	.tdo(tdo),
	.tdo_oe_n(tdo_oe_n),
	.core_out(core_out),
	.core_oe_n(core_oe_n),
	.dev_out(dev_out),
	.dev_oe_n(dev_oe_n),
	.bist_busy(bist_busy)
);

/* test/bst_jtag_host.sv */
`timescale 1ns/1ps
// ----
// Boundary-scan tester model
// ----
module bst_jtag_host (
	// Link driven by the tester
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	// Link returned by the device
	input wire logic tdo,
	input wire logic tdo_oe_n
);
	// Link stands still outside frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
	end
	// One tck cycle of 48 ns, tdo taken before the rise
	task automatic clk(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#24;
		o = tdo;
		tck = 1'b1;
		#24;
		tck = 1'b0;
	endtask
	task automatic step(input logic m);
		logic o;
		clk(m, 1'b0, o);
	endtask
	task automatic idle(input int n);
		repeat (n) step(1'b0);
	endtask
	// Test logic reset by trst_n and five tms high
	task automatic tap_reset(input logic use_trst);
		if (use_trst) begin
			trst_n = 1'b0;
			#48;
			trst_n = 1'b1;
		end
		repeat (5) step(1'b1);
		step(1'b0);
	endtask
	// Scan n bits LSB first from idle back to idle
	task automatic scan(input logic ir, input int n,
		input logic [391:0] din, output logic [391:0] dout);
		dout = '0;
		step(1'b1);
		if (ir) begin
			step(1'b1);
		end
		step(1'b0);
		step(1'b0);
		for (int i = 0; i < n; i++) begin
			clk(i == n - 1, din[i], dout[i]);
		end
		step(1'b1);
		step(1'b0);
	endtask
endmodule

/* test/test_boundary_scan_tap_with_selftest.sv */
`timescale 1ns/1ps
// ----
// Testbench
// ----
module test_boundary_scan_tap_with_selftest;
	localparam int OPS = 20;
	logic core_clk, resetn, tck, tms, tdi, trst_n, tdo, tdo_oe_n;
	logic read_fail, bist_busy;
	logic [bst_pkg::BSR_IN-1:0] pin_in;
	logic [bst_pkg::BSR_OUT-1:0] core_out, core_oe_n, dev_out, dev_oe_n;
	logic [391:0] d, pat;
	int n_mismatch, checked;

	// Core clock 25 MHz
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	bst_tap #(.SELFTEST_OPS(OPS)) i_dut (
		.core_clk(core_clk), .resetn(resetn), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
		.pin_in(pin_in), .core_out(core_out), .core_oe_n(core_oe_n),
		.dev_out(dev_out), .dev_oe_n(dev_oe_n),
		.read_fail(read_fail), .bist_busy(bist_busy)
	);
	bst_jtag_host i_host (
		.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdo_oe_n(tdo_oe_n)
	);

	task automatic chk(input string nm, input logic [391:0] e,
		input logic [391:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic finish_test;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic core_wait(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wait_busy(input logic lvl);
		int i;
		i = 0;
		while (bist_busy !== lvl && i < 200) begin
			@(negedge core_clk);
			i++;
		end
		if (bist_busy !== lvl) begin
			n_mismatch++;
			$display("mismatch bist_busy expected %b seen %b", lvl,
				bist_busy);
			finish_test;
		end
	endtask
	// Only listed instruction codes are ever loaded
	task automatic load_ir(input logic [3:0] c);
		i_host.scan(1'b1, 4, c, d);
	endtask
	task automatic set_mode(input logic [1:0] m);
		load_ir(bst_pkg::IR_MODESEL);
		i_host.scan(1'b0, 2, m, d);
	endtask
	task automatic run_bist(input logic [25:0] e);
		load_ir(bst_pkg::IR_RUNBIST);
		wait_busy(1'b1);
		wait_busy(1'b0);
		i_host.idle(6);
		load_ir(bst_pkg::IR_INTSCAN);
		i_host.scan(1'b0, 26, '0, d);
		chk("result", e[25:1], d[25:1]);
	endtask

	task automatic t_idcode;
		i_host.scan(1'b0, 32, '0, d);
		chk("id_reset", bst_pkg::ID_VALUE, d[31:0]);
		chk("id_bit0", 1'b1, d[0]);
		chk("busy_reset", 1'b0, bist_busy);
		i_host.scan(1'b1, 4, bst_pkg::IR_IDCODE, d);
		chk("ir_capture", bst_pkg::IR_CAPTURE, d[3:0]);
		i_host.scan(1'b0, 40, 8'ha5, d);
		chk("id_load", bst_pkg::ID_VALUE, d[31:0]);
		chk("id_length", 8'ha5, d[39:32]);
	endtask
	task automatic t_bypass;
		logic [3:0] c [3];
		logic [191:0] e [3];
		c = '{bst_pkg::IR_BYPASS, bst_pkg::IR_HIGHZ, bst_pkg::IR_CLAMP};
		e = '{core_oe_n, {192{1'b1}}, {192{1'b0}}};
		foreach (c[k]) begin
			load_ir(c[k]);
			i_host.scan(1'b0, 8, 8'ha5, d);
			chk("bypass", 8'h4a, d[7:0]);
			core_wait(6);
			chk("dev_oe_n", e[k], dev_oe_n);
		end
	endtask
	task automatic t_boundary;
		pat = {{48{4'h9}}, {50{4'h6}}};
		@(negedge core_clk);
		pin_in = {25{8'h3c}};
		i_host.idle(3);
		load_ir(bst_pkg::IR_SAMPLE);
		i_host.scan(1'b0, 392, pat, d);
		chk("sample", pin_in, d[199:0]);
		load_ir(bst_pkg::IR_EXTEST);
		core_wait(6);
		chk("extest_out", pat[391:200], dev_out);
		chk("extest_oe_n", '0, dev_oe_n);
		i_host.scan(1'b0, 392, '0, d);
		chk("extest_path", pin_in, d[199:0]);
	endtask
	task automatic t_selftest;
		set_mode(bst_pkg::MODE_FORCE_FAIL);
		run_bist({24'h8e_0000, 2'b00});
		@(negedge core_clk);
		resetn = 1'b0;
		core_wait(2);
		resetn = 1'b1;
		i_host.tap_reset(1'b0);
		run_bist({24'h8e_0000, 2'b00});
		set_mode(bst_pkg::MODE_NORMAL);
		run_bist({24'h00_0000, 2'b10});
		@(negedge core_clk);
		read_fail = 1'b1;
		run_bist({24'(OPS), 2'b00});
		read_fail = 1'b0;
	endtask

	// Main sequence
	initial begin
		resetn = 1'b0;
		read_fail = 1'b0;
		pin_in = '0;
		core_out = {24{8'h5a}};
		core_oe_n = {96{2'b01}};
		n_mismatch = 0;
		checked = 0;
		core_wait(3);
		resetn = 1'b1;
		i_host.tap_reset(1'b1);
		t_idcode;
		t_bypass;
		t_boundary;
		t_selftest;
		finish_test;
	end
endmodule
